/* File: tcc_pkg.sv */
// Constants and types for the thermostat control core
package tcc_pkg;

  // Timing
  localparam int CLK_KHZ = 100000;
  localparam int TICK_MS = 1000;
  localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;
  localparam logic [1:0] KEY_ONOFF_S = 2'h1;
  localparam logic [1:0] KEY_PEAK_S = 2'h3;
  localparam logic [3:0] ECO_LABEL_S = 4'ha;
  localparam logic [1:0] INIT_LOAD = 2'h2;
  localparam logic [1:0] INIT_DONE = 2'h3;

  // Register byte offsets
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_SETP = 8'h04;
  localparam logic [7:0] OFS_HYST = 8'h08;
  localparam logic [7:0] OFS_LIMIT = 8'h0c;
  localparam logic [7:0] OFS_DLY_A = 8'h10;
  localparam logic [7:0] OFS_DLY_B = 8'h14;
  localparam logic [7:0] OFS_DLY_C = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_PEAK = 8'h20;

  // Field positions
  localparam int CFG_IFS_LSB = 0;
  localparam int CFG_UNIT_LSB = 4;
  localparam int CFG_DIR_BIT = 6;
  localparam int CFG_KEY_LSB = 7;
  localparam int CFG_ECOV_BIT = 9;
  localparam int LO_LSB = 0;
  localparam int HI_LSB = 16;
  localparam int D0_LSB = 0;
  localparam int D1_LSB = 8;
  localparam int D2_LSB = 16;
  localparam int D3_LSB = 24;

  // Reset values
  localparam logic [31:0] CFG_RST = 32'h0000_0190;
  localparam logic [31:0] SETP_RST = 32'h0000_0000;
  localparam logic [31:0] HYST_RST = 32'h0014_0014;
  localparam logic [31:0] LIMIT_RST = 32'h01f4_fe0c;
  localparam logic [31:0] DLY_RST = 32'h0000_0000;
  localparam logic [7:0] CNT_FULL = 8'hff;

  typedef enum logic [1:0] {
    UNIT_C_1, UNIT_C_01, UNIT_F_1, UNIT_F_01
  } tcc_unit_t;

  typedef enum logic [2:0] {
    DISP_OFF, DISP_MAIN, DISP_ECO, DISP_DOOR, DISP_EXT, DISP_HOLD
  } tcc_disp_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic [31:0] cfg, setp, hyst, limit, dly_a, dly_b, dly_c;
    logic key1_m, key1_s, key2_m, key2_s, di_m, di_s, nv_m, nv_s;
    logic [1:0] init_cnt;
    logic run_on;
    logic [31:0] pre_div;
    logic tick;
    logic [3:0] alt_cnt;
    logic [1:0] key1_cnt, key2_cnt;
    logic key1_done, key2_done;
    logic di_act;
    logic [7:0] di_cnt;
    logic eco, eco_by_door;
    logic [7:0] closed_cnt, eco_cnt, door_cnt;
    logic door_alarm, ext_alarm, demand, fault_on, out, out_led;
    logic [7:0] fault_cnt, req_cnt, off_cnt, on_cnt, hold_cnt;
    logic pk_valid;
    logic [15:0] pk_min, pk_max;
    tcc_disp_t disp;
  } tcc_state_t;

endpackage

/* File: tcc_core.sv */
// Thermostat on/off control core with Wishbone register slave
//
// What this block does
// - Stand-by runs no control, blanks display but stand-by lamp, eco lamp keeps its state; exit restarts.
// - After power loss, resume the ON or stand-by state stored before.
// - Key function 3 held 1 s toggles ON; input function 7 selects ON.
// - Normal and economy setpoints with own hysteresis; function 6 picks economy.
// - Automatic economy entry after entry delay following door closure.
// - Door opening leaves economy if door-based entry started it.
// - Economy ends after timeout from closure and activation; zero disables.
// - Automatic economy only with door functions 1..3; zero entry delay off.
// - Economy label steady in economy view, else shown every 10 s.
// - Normal setpoint clamped to limits; economy between normal and high.
// - Unit select encodes C/1, C/0.1, F/1, F/0.1.
// - Track min/max probe peaks; 3 s key hold restarts them from now.
// - Input actions wait the action delay; function 0 does nothing.
// - Door functions show door-open, time door alarm delay, then alarm.
// - Function 3 locks output while door open until the door alarm.
// - Function 4 external alarm only; function 5 also disables output.
// - Negative function codes act the same with inverted contact polarity.
// - On/off control: hysteresis above setpoint cooling, below heating.
// - Probe error cycles output run/stop; zero run off, zero stop on.
// - Output enabled only after start delay, min off and restart interval.
// - Startup hold keeps output off, shows hold; output lamp blinks while start delay, min off or restart interval inhibit.
// - Any protection or startup delay set to zero applies no inhibition.
`timescale 1ns/100ps
module tcc_core import tcc_pkg::*; #(
  parameter int TICK_CYC = TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Probe, same clock domain
  input wire logic [15:0] main_probe_i,
  input wire logic probe_err_i,
  // Front pins
  input wire logic key_first_i,
  input wire logic key_peak_i,
  input wire logic door_contact_i,
  // Retained run state
  input wire logic retained_on_i,
  output logic run_state_o,
  // Relay and panel
  output logic relay_o,
  output logic out_led_o,
  output logic standby_led_o,
  output logic alarm_o,
  output logic eco_o,
  output tcc_disp_t disp_sel_o,
  output tcc_unit_t unit_sel_o
);

  localparam logic [31:0] TICK_LAST = 32'(TICK_CYC - 1);

  tcc_state_t s;
  tcc_state_t n;

  function automatic logic [7:0] sat8(input logic [7:0] v);
    sat8 = (v == CNT_FULL) ? v : v + 8'h01;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    merge = r;
  endfunction

  // Decoded configuration
  logic [3:0] fn_raw;
  logic fn_neg;
  logic [3:0] fn;
  logic door_fn;
  logic di_raw;
  logic [7:0] iti, eco_entry_delay, eco_timeout, door_alarm_delay;
  logic [7:0] fault_run_time, fault_stop_time;
  logic [7:0] start_delay, min_off_time, min_restart_interval, hold_time;
  logic signed [16:0] t, lo_lim, hi_lim, sp_req, spe_req;
  logic signed [16:0] sp_n, sp_e, sp_a, hy_a;
  logic active, restart, on_n, door_open, lock, want, req;
  logic hold_done, start_ok, off_ok, on_ok;
  logic [31:0] rd;

  always_comb begin
    fn_raw = s.cfg[CFG_IFS_LSB +: 4];
    fn_neg = fn_raw[3];
    fn = fn_neg ? 4'(-fn_raw) : fn_raw;
    door_fn = (fn == 4'h1) || (fn == 4'h2) || (fn == 4'h3);
    di_raw = (fn != 4'h0) && (s.di_s ^ fn_neg);
    iti = s.dly_a[D0_LSB +: 8];
    eco_entry_delay = s.dly_a[D1_LSB +: 8];
    eco_timeout = s.dly_a[D2_LSB +: 8];
    door_alarm_delay = s.dly_a[D3_LSB +: 8];
    fault_run_time = s.dly_b[D0_LSB +: 8];
    fault_stop_time = s.dly_b[D1_LSB +: 8];
    start_delay = s.dly_b[D2_LSB +: 8];
    min_off_time = s.dly_b[D3_LSB +: 8];
    min_restart_interval = s.dly_c[D0_LSB +: 8];
    hold_time = s.dly_c[D1_LSB +: 8];
    t = {main_probe_i[15], main_probe_i};
    lo_lim = {s.limit[LO_LSB + 15], s.limit[LO_LSB +: 16]};
    hi_lim = {s.limit[HI_LSB + 15], s.limit[HI_LSB +: 16]};
    sp_req = {s.setp[LO_LSB + 15], s.setp[LO_LSB +: 16]};
    spe_req = {s.setp[HI_LSB + 15], s.setp[HI_LSB +: 16]};
    // Setpoint window
    sp_n = (sp_req < lo_lim) ? lo_lim : (sp_req > hi_lim) ? hi_lim : sp_req;
    sp_e = (spe_req < sp_n) ? sp_n : (spe_req > hi_lim) ? hi_lim : spe_req;
    sp_a = s.eco ? sp_e : sp_n;
    hy_a = s.eco ? {1'b0, s.hyst[HI_LSB +: 16]} : {1'b0, s.hyst[LO_LSB +: 16]};
  end

  always_comb begin
    n = s;
    // Bus slave: ack one cycle after request, write on acked edge
    n.ack = wb_cyc_i && wb_stb_i && !s.ack;
    rd = 32'h0000_0000;
    case (wb_adr_i)
      OFS_CFG: rd = s.cfg;
      OFS_SETP: rd = s.setp;
      OFS_HYST: rd = s.hyst;
      OFS_LIMIT: rd = s.limit;
      OFS_DLY_A: rd = s.dly_a;
      OFS_DLY_B: rd = s.dly_b;
      OFS_DLY_C: rd = s.dly_c;
      OFS_STATUS: rd = {22'h0, s.fault_on, probe_err_i, !hold_done_f(s),
                        s.ext_alarm, s.door_alarm, s.di_act && door_fn,
                        s.out, s.eco, s.run_on, s.demand};
      OFS_PEAK: rd = {s.pk_max, s.pk_min};
      default: rd = 32'h0000_0000;
    endcase
    if (wb_cyc_i && wb_stb_i && !s.ack) begin
      n.dat = rd;
    end
    if (wb_cyc_i && wb_stb_i && s.ack && wb_we_i) begin
      case (wb_adr_i)
        OFS_CFG: n.cfg = merge(s.cfg, wb_dat_i, wb_sel_i);
        OFS_SETP: n.setp = merge(s.setp, wb_dat_i, wb_sel_i);
        OFS_HYST: n.hyst = merge(s.hyst, wb_dat_i, wb_sel_i);
        OFS_LIMIT: n.limit = merge(s.limit, wb_dat_i, wb_sel_i);
        OFS_DLY_A: n.dly_a = merge(s.dly_a, wb_dat_i, wb_sel_i);
        OFS_DLY_B: n.dly_b = merge(s.dly_b, wb_dat_i, wb_sel_i);
        OFS_DLY_C: n.dly_c = merge(s.dly_c, wb_dat_i, wb_sel_i);
        default: n.cfg = s.cfg;
      endcase
    end

    // Pin synchronisers
    n.key1_m = key_first_i;
    n.key1_s = s.key1_m;
    n.key2_m = key_peak_i;
    n.key2_s = s.key2_m;
    n.di_m = door_contact_i;
    n.di_s = s.di_m;
    n.nv_m = retained_on_i;
    n.nv_s = s.nv_m;

    // One-second time base
    n.tick = 1'b0;
    if (s.pre_div == TICK_LAST) begin
      n.pre_div = 32'h0000_0000;
      n.tick = 1'b1;
    end else begin
      n.pre_div = s.pre_div + 32'h0000_0001;
    end
    if (s.tick) begin
      n.alt_cnt = (s.alt_cnt == ECO_LABEL_S - 4'h1) ? 4'h0
                                                   : s.alt_cnt + 4'h1;
    end

    // Input action delay
    if (di_raw != s.di_act) begin
      if (s.di_cnt >= iti) begin
        n.di_act = di_raw;
        n.di_cnt = 8'h00;
      end else if (s.tick) begin
        n.di_cnt = sat8(s.di_cnt);
      end
    end else begin
      n.di_cnt = 8'h00;
    end

    // Run state: retained value loaded once after reset release
    on_n = s.run_on;
    restart = 1'b0;
    if (s.init_cnt != INIT_DONE) begin
      n.init_cnt = s.init_cnt + 2'h1;
    end
    if (s.init_cnt == INIT_LOAD) begin
      on_n = s.nv_s;
      restart = s.nv_s;
    end

    // First key hold
    if (s.key1_s) begin
      if (s.tick && !s.key1_done) begin
        n.key1_cnt = s.key1_cnt + 2'h1;
      end
      if (s.key1_cnt == KEY_ONOFF_S && !s.key1_done) begin
        n.key1_done = 1'b1;
        if (s.cfg[CFG_KEY_LSB +: 2] == 2'h3) begin
          on_n = !s.run_on;
        end else if (s.cfg[CFG_KEY_LSB +: 2] == 2'h2 && s.run_on) begin
          n.eco = !s.eco;
          n.eco_by_door = 1'b0;
        end
      end
    end else begin
      n.key1_cnt = 2'h0;
      n.key1_done = 1'b0;
    end
    if (fn == 4'h7 && s.init_cnt == INIT_DONE) begin
      on_n = s.di_act;
    end
    if (on_n && !s.run_on && s.init_cnt == INIT_DONE) begin
      restart = 1'b1;
    end
    n.run_on = on_n;
    active = s.run_on && (s.init_cnt == INIT_DONE);

    // Economy selection
    if (active && fn == 4'h6) begin
      n.eco = s.di_act;
      n.eco_by_door = 1'b0;
    end
    if (active && door_fn && eco_entry_delay != 8'h00) begin
      if (s.di_act) begin
        n.closed_cnt = 8'h00;
        if (s.eco_by_door) begin
          n.eco = 1'b0;
          n.eco_by_door = 1'b0;
        end
      end else if (s.tick && s.closed_cnt != CNT_FULL) begin
        n.closed_cnt = sat8(s.closed_cnt);
        if (sat8(s.closed_cnt) == eco_entry_delay && !s.eco) begin
          n.eco = 1'b1;
          n.eco_by_door = 1'b1;
          n.eco_cnt = 8'h00;
        end
      end
      if (s.eco && s.eco_by_door && !s.di_act
          && eco_timeout != 8'h00) begin
        if (s.eco_cnt >= eco_timeout) begin
          n.eco = 1'b0;
          n.eco_by_door = 1'b0;
        end else if (s.tick) begin
          n.eco_cnt = sat8(s.eco_cnt);
        end
      end
    end

    // Door and external alarms
    door_open = active && door_fn && s.di_act;
    if (door_open) begin
      if (s.door_cnt >= door_alarm_delay) begin
        n.door_alarm = 1'b1;
      end else if (s.tick) begin
        n.door_cnt = sat8(s.door_cnt);
      end
    end else begin
      n.door_cnt = 8'h00;
      n.door_alarm = 1'b0;
    end
    n.ext_alarm = active && s.di_act
                  && (fn == 4'h4 || fn == 4'h5);
    lock = (fn == 4'h3 && door_open && !s.door_alarm)
           || (fn == 4'h5 && active && s.di_act);

    // Hysteresis control
    if (!s.cfg[CFG_DIR_BIT]) begin
      if (t >= sp_a + hy_a) begin
        n.demand = 1'b1;
      end else if (t <= sp_a) begin
        n.demand = 1'b0;
      end
    end else begin
      if (t <= sp_a - hy_a) begin
        n.demand = 1'b1;
      end else if (t >= sp_a) begin
        n.demand = 1'b0;
      end
    end

    // Fault cycling on probe error
    if (probe_err_i) begin
      if (s.tick) begin
        n.fault_cnt = sat8(s.fault_cnt);
      end
      if (s.fault_on && s.fault_cnt >= fault_run_time) begin
        n.fault_on = 1'b0;
        n.fault_cnt = 8'h00;
      end else if (!s.fault_on && s.fault_cnt >= fault_stop_time) begin
        n.fault_on = 1'b1;
        n.fault_cnt = 8'h00;
      end
    end else begin
      n.fault_cnt = 8'h00;
      n.fault_on = 1'b1;
    end
    want = (fault_run_time == 8'h00) ? 1'b0
         : (fault_stop_time == 8'h00) ? 1'b1 : s.fault_on;

    // Startup hold and protection timers
    hold_done = hold_done_f(s);
    if (s.tick) begin
      n.hold_cnt = sat8(s.hold_cnt);
      n.on_cnt = sat8(s.on_cnt);
      if (!s.out) begin
        n.off_cnt = sat8(s.off_cnt);
      end
    end
    req = active && hold_done && !lock
          && (probe_err_i ? want : s.demand);
    if (!req) begin
      n.req_cnt = 8'h00;
    end else if (s.tick) begin
      n.req_cnt = sat8(s.req_cnt);
    end
    start_ok = s.req_cnt >= start_delay;
    off_ok = s.off_cnt >= min_off_time;
    on_ok = s.on_cnt >= min_restart_interval;
    n.out = s.out ? req : (req && start_ok && off_ok && on_ok);
    if (!s.out && n.out) begin
      n.on_cnt = 8'h00;
    end
    if (s.out) begin
      n.off_cnt = 8'h00;
    end
    n.out_led = s.out || (req && s.alt_cnt[0]);

    // Fresh start on power-up or leaving stand-by
    if (restart || !active) begin
      n.hold_cnt = 8'h00;
      n.req_cnt = 8'h00;
      n.off_cnt = CNT_FULL;
      n.on_cnt = CNT_FULL;
      n.out = 1'b0;
      n.out_led = 1'b0;
      n.door_cnt = 8'h00;
      n.door_alarm = 1'b0;
      n.fault_cnt = 8'h00;
      n.fault_on = 1'b1;
    end

    // Peak tracking
    if (s.key2_s) begin
      if (s.tick && !s.key2_done) begin
        n.key2_cnt = s.key2_cnt + 2'h1;
      end
      if (s.key2_cnt == KEY_PEAK_S && !s.key2_done) begin
        n.key2_done = 1'b1;
        n.pk_valid = 1'b0;
      end
    end else begin
      n.key2_cnt = 2'h0;
      n.key2_done = 1'b0;
    end
    if (!probe_err_i) begin
      if (!s.pk_valid) begin
        n.pk_valid = 1'b1;
        n.pk_min = main_probe_i;
        n.pk_max = main_probe_i;
      end else begin
        if ($signed(main_probe_i) < $signed(s.pk_min)) begin
          n.pk_min = main_probe_i;
        end
        if ($signed(main_probe_i) > $signed(s.pk_max)) begin
          n.pk_max = main_probe_i;
        end
      end
    end

    // Display selection
    if (!active) begin
      n.disp = DISP_OFF;
    end else if (!hold_done && s.alt_cnt[0]) begin
      n.disp = DISP_HOLD;
    end else if (door_open && s.alt_cnt[0]) begin
      n.disp = DISP_DOOR;
    end else if (s.ext_alarm && s.alt_cnt[0]) begin
      n.disp = DISP_EXT;
    end else if (s.eco && (s.cfg[CFG_ECOV_BIT] || s.alt_cnt == 4'h0)) begin
      n.disp = DISP_ECO;
    end else begin
      n.disp = DISP_MAIN;
    end
  end

  function automatic logic hold_done_f(input tcc_state_t st);
    hold_done_f = st.hold_cnt >= st.dly_c[D1_LSB +: 8];
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.cfg <= CFG_RST;
      s.setp <= SETP_RST;
      s.hyst <= HYST_RST;
      s.limit <= LIMIT_RST;
      s.dly_a <= DLY_RST;
      s.dly_b <= DLY_RST;
      s.dly_c <= DLY_RST;
      s.off_cnt <= CNT_FULL;
      s.on_cnt <= CNT_FULL;
      s.fault_on <= 1'b1;
      s.disp <= DISP_OFF;
    end else begin
      s <= n;
    end
  end

  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.dat;
  assign run_state_o = s.run_on;
  assign relay_o = s.out;
  assign out_led_o = s.out_led;
  assign standby_led_o = !s.run_on;
  assign alarm_o = s.door_alarm || s.ext_alarm;
  assign eco_o = s.eco;
  assign disp_sel_o = s.disp;
  assign unit_sel_o = tcc_unit_t'(s.cfg[CFG_UNIT_LSB +: 2]);

endmodule // tcc_core

/* File: tcc_core_chk.sv */
// Port assertions for the thermostat control core
`timescale 1ns/100ps
module tcc_core_chk import tcc_pkg::*; (
  // Clock and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Relay and panel
  input wire logic run_state_o,
  input wire logic relay_o,
  input wire logic standby_led_o,
  input wire logic alarm_o,
  input wire logic eco_o,
  input tcc_disp_t disp_sel_o,
  input tcc_unit_t unit_sel_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  unmapped_read_a: assert property (wb_cyc_i && wb_stb_i && !wb_we_i
    && !wb_ack_o && wb_adr_i == 8'h24 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  standby_relay_a: assert property (standby_led_o [*2] |-> !relay_o)
    else $error("relay on in stand-by");
  standby_blank_a: assert property (standby_led_o [*2] |-> disp_sel_o == DISP_OFF)
    else $error("display not blank in stand-by");
  run_lamp_a: assert property (run_state_o |-> !standby_led_o)
    else $error("stand-by lamp lit while running");
  relay_rise_a: assert property ($rose(relay_o) |-> !$past(standby_led_o))
    else $error("relay rose out of stand-by");
  reset_off_a: assert property (disable iff (1'b0) rst_i |=> !relay_o && standby_led_o && !run_state_o)
    else $error("outputs not quiet after reset");
  unit_write_a: assert property ($changed(unit_sel_o) |->
    $past(wb_ack_o && wb_we_i) || $past(rst_i))
    else $error("unit select changed without a write");

  cover property ($rose(relay_o));
  cover property ($rose(alarm_o));
  cover property ($rose(standby_led_o));
  cover property ($rose(eco_o));
endmodule // tcc_core_chk

bind tcc_core tcc_core_chk u_tcc_core_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .run_state_o(run_state_o), .relay_o(relay_o),
  .standby_led_o(standby_led_o), .alarm_o(alarm_o), .eco_o(eco_o),
  .disp_sel_o(disp_sel_o), .unit_sel_o(unit_sel_o));

/* File: tcc_plant.sv */
// Far-side model: probe and door contact
`timescale 1ns/100ps
module tcc_plant import tcc_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bench commands
  input wire logic [15:0] temp_i,
  input wire logic err_i,
  input wire logic door_i,
  // Core side
  output logic [15:0] main_probe_o,
  output logic probe_err_o,
  output logic door_contact_o
);
  logic door_ff;
  logic [1:0] bounce_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_probe_o <= 16'h0;
      probe_err_o <= 1'b0;
      door_ff <= 1'b0;
      bounce_ff <= 2'h0;
    end else begin
      // Open probe reads junk
      main_probe_o <= err_i ? 16'h8000 : temp_i;
      probe_err_o <= err_i;
      if (door_i != door_ff) begin
        door_ff <= door_i;
        bounce_ff <= 2'h3;
      end else if (bounce_ff != 2'h0) begin
        bounce_ff <= bounce_ff - 2'h1;
      end
    end
  end
  // Contact chatters for three cycles on each change
  assign door_contact_o = (bounce_ff != 2'h0) ? bounce_ff[0] : door_ff;
endmodule // tcc_plant

/* File: tcc_core_tb.sv */
// Self-checking bench for the thermostat control core
`timescale 1ns/100ps
module tcc_core_tb import tcc_pkg::*;;
  localparam int T = 20;
  localparam int RLY = 0, RUN = 1, SBY = 2;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, perr, contact, run_st, relay, oled, sled, alarm, eco;
  logic [15:0] temp = 16'h0, probe;
  logic err = 1'b0, door = 1'b0, key1 = 1'b0, key2 = 1'b0, retained = 1'b1;
  logic [4:0] mon;
  tcc_disp_t disp;
  tcc_unit_t unit;
  int failures = 0;
  int compares = 0;
  logic [3:0] fns [8] = '{4'h0, 4'h6, 4'ha, 4'h4, 4'h5, 4'hb, 4'h1, 4'h7};
  // Driven door level, eco, alarm, relay
  logic [3:0] exps [8] = '{4'h9, 4'hd, 4'h5, 4'hb, 4'ha, 4'h2, 4'hb, 4'h0};

  always #5 clk_i = ~clk_i;
  assign mon = {eco, alarm, sled, run_st, relay};

  tcc_plant u_tcc_plant (.clk_i(clk_i), .rst_i(rst_i), .temp_i(temp),
    .err_i(err), .door_i(door), .main_probe_o(probe), .probe_err_o(perr),
    .door_contact_o(contact));
  tcc_core #(.TICK_CYC(T)) u_tcc_core (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .main_probe_i(probe), .probe_err_i(perr), .key_first_i(key1),
    .key_peak_i(key2), .door_contact_i(contact), .retained_on_i(retained),
    .run_state_o(run_st), .relay_o(relay), .out_led_o(oled),
    .standby_led_o(sled), .alarm_o(alarm), .eco_o(eco),
    .disp_sel_o(disp), .unit_sel_o(unit));

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(negedge clk_i);
    chk("bus ack", 32'h1, {31'h0, ack === 1'b0 && n < 20});
    if (n >= 20) complete_run();
  endtask

  task automatic wait_for(input string what, input int b, input logic v,
                          input int lim);
    int n = 0;
    while (mon[b] !== v && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    chk(what, {31'h0, v}, {31'h0, mon[b]});
    if (mon[b] !== v) complete_run();
  endtask

  task automatic hold_key(input logic peak, input int n);
    @(posedge clk_i);
    if (peak) key2 <= 1'b1;
    else key1 <= 1'b1;
    repeat (n) @(posedge clk_i);
    key1 <= 1'b0;
    key2 <= 1'b0;
    repeat (2 * T) @(negedge clk_i);
  endtask

  task automatic t_regs();
    wb(0, OFS_CFG, 4'hf, 0);
    chk("cfg", CFG_RST, q);
    wb(0, OFS_LIMIT, 4'hf, 0);
    chk("limit", LIMIT_RST, q);
    wb(0, OFS_DLY_B, 4'hf, 0);
    chk("delay", DLY_RST, q);
    wb(0, 8'h24, 4'hf, 0);
    chk("unmapped", 32'h0, q);
    wb(1, OFS_HYST, 4'h2, 32'h1234_5678);
    wb(0, OFS_HYST, 4'hf, 0);
    chk("hyst lane", 32'h0014_5614, q);
    wb(1, OFS_HYST, 4'hf, HYST_RST);
    for (int i = 2; i < 6; i++) begin
      wb(1, OFS_CFG, 4'hf, (CFG_RST & 32'hffff_ffcf) | ((i % 4) << 4));
      chk("unit", i % 4, {30'h0, unit});
    end
    $display("registers done");
  endtask

  task automatic t_onoff();
    wait_for("run after power-up", RUN, 1'b1, 10);
    hold_key(1'b0, 2 * T);
    chk("stand-by lamp", 32'h1, {31'h0, sled});
    chk("relay in stand-by", 32'h0, {31'h0, relay});
    chk("display in stand-by", DISP_OFF, {29'h0, disp});
    @(posedge clk_i);
    retained <= 1'b0;
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (10) @(negedge clk_i);
    chk("stand-by over reset", 32'h1, {31'h0, sled});
    hold_key(1'b0, 2 * T);
    chk("run after key", 32'h1, {31'h0, run_st});
    $display("on and stand-by done");
  endtask

  task automatic t_peak();
    @(posedge clk_i);
    temp <= 16'd50;
    repeat (10) @(posedge clk_i);
    temp <= 16'hfff6;
    repeat (10) @(posedge clk_i);
    temp <= 16'd20;
    wb(0, OFS_PEAK, 4'hf, 0);
    chk("peaks", 32'h0032_fff6, q);
    hold_key(1'b1, 4 * T);
    wb(0, OFS_PEAK, 4'hf, 0);
    chk("peaks cleared", 32'h0014_0014, q);
    $display("peaks done");
  endtask

  task automatic t_control(input logic heat, input logic [15:0] on_t,
                           input logic [15:0] mid_t);
    wb(1, OFS_CFG, 4'hf, CFG_RST | {25'h0, heat, 6'h0});
    temp <= on_t;
    wait_for("relay on at edge", RLY, 1'b1, 3 * T);
    temp <= mid_t;
    repeat (2 * T) @(negedge clk_i);
    chk("relay in band", 32'h1, {31'h0, relay});
    chk("output lamp", 32'h1, {31'h0, oled});
    temp <= 16'h0;
    wait_for("relay off at setpoint", RLY, 1'b0, 3 * T);
    $display("control done");
  endtask

  task automatic t_fault();
    int n = 0;
    wb(1, OFS_DLY_B, 4'hf, 32'h0000_0302);
    err <= 1'b1;
    wait_for("fault run", RLY, 1'b1, 6 * T);
    while (relay === 1'b1 && n < 10 * T) begin
      @(negedge clk_i);
      n++;
    end
    chk("run length", 32'h1, {31'h0, n >= T && n <= 3 * T});
    n = 0;
    while (relay === 1'b0 && n < 10 * T) begin
      @(negedge clk_i);
      n++;
    end
    chk("stop length", 32'h1, {31'h0, n >= 2 * T && n <= 4 * T});
    wb(1, OFS_DLY_B, 4'hf, 32'h0000_0300);
    wait_for("run time off", RLY, 1'b0, 6 * T);
    wb(1, OFS_DLY_B, 4'hf, 32'h0000_0002);
    wait_for("stop time off", RLY, 1'b1, 6 * T);
    repeat (6 * T) @(negedge clk_i);
    chk("stays on", 32'h1, {31'h0, relay});
    err <= 1'b0;
    wb(1, OFS_DLY_B, 4'hf, 32'h0);
    wait_for("fault over", RLY, 1'b0, 3 * T);
    $display("probe fault done");
  endtask

  task automatic t_inputs();
    temp <= 16'd20;
    for (int i = 0; i < 8; i++) begin
      wb(1, OFS_CFG, 4'hf, CFG_RST | {28'h0, fns[i]});
      door <= exps[i][3];
      repeat (4 * T) @(negedge clk_i);
      chk("eco", exps[i][2], {31'h0, eco});
      chk("alarm", exps[i][1], {31'h0, alarm});
      chk("relay", exps[i][0], {31'h0, relay});
      @(posedge clk_i);
      door <= ~exps[i][3];
      repeat (4 * T) @(negedge clk_i);
    end
    wait_for("input selects run", RUN, 1'b1, 3 * T);
    $display("digital input done");
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_onoff();
    t_peak();
    t_control(1'b0, 16'd20, 16'd10);
    t_control(1'b1, 16'hffec, 16'hfff6);
    t_fault();
    t_inputs();
    complete_run();
  end
endmodule // tcc_core_tb
